// >>> hw/spfs_cfg_reg.sv
`timescale 1ns/1ps
// Resettable configuration register with write strobe
module spfs_cfg_reg #(
    parameter int          W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic          core_clk,  // System clock
    input  wire logic          rstn,      // Sync reset, low
    input  wire logic          we,        // Write strobe
    input  wire logic [W-1:0]  wdata,     // Write data
    output logic      [W-1:0]  q          // Register value
);
    // -------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            q <= RST;
        end else if (we) begin
            q <= wdata;
        end
    end
endmodule // spfs_cfg_reg

// >>> hw/spfs_pad_mux.sv
`timescale 1ns/1ps
// One pad: GPIO or peripheral, with bus idle tri-state
module spfs_pad_mux (
    input  wire logic           core_clk,  // System clock
    input  wire logic           rstn,      // Sync reset, low
    input  wire logic           per_en,    // Peripheral owns pad
    input  wire logic           gpio_dir,  // 1 drives GPIO out
    input  wire logic           gpio_out,  // GPIO level
    input  wire logic           per_out,   // Peripheral level
    input  wire logic           per_oe,    // Peripheral drives
    input  wire logic           pu_en,     // Pull-up enable bit
    output spfs_pkg::spfs_pad_t pad        // Pad control
);
    // Selected drive
    wire logic sel_out = per_en ? per_out : gpio_out;
    wire logic sel_oe  = per_en ? per_oe  : gpio_dir;

    // Registered pad drive
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pad <= '{out: 1'b0, oe_n: 1'b1, pu: 1'b1};
        end else begin
            pad <= '{out: sel_out, oe_n: ~sel_oe, pu: pu_en};
        end
    end
endmodule // spfs_pad_mux

// >>> hw/spfs_top.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------
// Overview of operation
// - Port B line four resets to GPIO
// - Clock select picks address or prescaler clock
// - Port B bit four clears line-four pull-up
// - Bus pins tri-state when idle per drive bit
// - Port F resets to bus, software selects GPIO
// - Port F pull-up bits, line zero bit zero
// - Chip-select port D lines reset to GPIO
// - Chip selects come from memory interface decode
// - Port D pull-up bits, line zero bit zero
// - Serial zero transmit default, port E bit zero
// - Serial zero receive default, port E bit one
// - Serial one transmit default, port D bit six
// - Each GPIO line has own direction
// -----------------------------------------------------------------------
module spfs_top (
    input  wire logic                  core_clk,        // 100 MHz clock
    input  wire logic                  rstn,            // Sync reset, low
    input  wire spfs_pkg::spfs_wr_t    pb_pur_wr,       // Port B pull-up wr
    input  wire spfs_pkg::spfs_wr_t    pf_pur_wr,       // Port F pull-up wr
    input  wire spfs_pkg::spfs_wr_t    pd_pur_wr,       // Port D pull-up wr
    input  wire spfs_pkg::spfs_wr_t    pe_pur_wr,       // Port E pull-up wr
    input  wire spfs_pkg::spfs_wr_t    pb_per_wr,       // Port B periph wr
    input  wire spfs_pkg::spfs_wr_t    pf_per_wr,       // Port F periph wr
    input  wire spfs_pkg::spfs_wr_t    pd_per_wr,       // Port D periph wr
    input  wire spfs_pkg::spfs_wr_t    pe_per_wr,       // Port E periph wr
    input  wire logic                  clk_out_sel_we,  // Clock select wr
    input  wire logic                  clk_out_sel_wd,  // 1 = prescaler
    input  wire logic [17:0]           gpio_dir,        // B4,F,D,E dirs
    input  wire logic [17:0]           gpio_out,        // B4,F,D,E levels
    input  wire logic                  bus_drive_select,// Drive when idle
    input  wire logic                  bus_active,      // External cycle
    input  wire logic                  address_line_twenty, // Addr 20
    input  wire logic                  prescaler_clk,   // Divided clock
    input  wire logic [3:0]            data_out,        // Data bits 7..10
    input  wire logic                  data_oe,         // Write cycle
    input  wire logic [5:0]            cs_n_in,         // Decoded selects
    input  wire logic                  serial_zero_transmit, // Tx0 level
    input  wire logic                  serial_one_transmit,  // Tx1 level
    output spfs_pkg::spfs_pad_t [17:0] pads,            // Pad controls
    output logic [4:0]                 pb_pur_q,        // Port B pull-ups
    output logic [3:0]                 pf_pur_q,        // Port F pull-ups
    output logic [7:0]                 pd_pur_q,        // Port D pull-ups
    output logic [1:0]                 pe_pur_q,        // Port E pull-ups
    output logic [17:0]                per_en_q,        // Function select
    output logic                       clk_out_sel_q    // Clock select
);
    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    logic [4:0] pb_per_q;
    logic [3:0] pf_per_q;
    logic [7:0] pd_per_q;
    logic [1:0] pe_per_q;

    spfs_cfg_reg #(.W(spfs_pkg::PB_W), .RST(spfs_pkg::PB_PUR_RST)) u_pbpu (
        .core_clk(core_clk), .rstn(rstn), .we(pb_pur_wr.we),
        .wdata(pb_pur_wr.data[4:0]), .q(pb_pur_q));
    spfs_cfg_reg #(.W(spfs_pkg::PF_W), .RST(spfs_pkg::PF_PUR_RST)) u_pfpu (
        .core_clk(core_clk), .rstn(rstn), .we(pf_pur_wr.we),
        .wdata(pf_pur_wr.data[3:0]), .q(pf_pur_q));
    spfs_cfg_reg #(.W(spfs_pkg::PD_W), .RST(spfs_pkg::PD_PUR_RST)) u_pdpu (
        .core_clk(core_clk), .rstn(rstn), .we(pd_pur_wr.we),
        .wdata(pd_pur_wr.data), .q(pd_pur_q));
    spfs_cfg_reg #(.W(spfs_pkg::PE_W), .RST(spfs_pkg::PE_PUR_RST)) u_pepu (
        .core_clk(core_clk), .rstn(rstn), .we(pe_pur_wr.we),
        .wdata(pe_pur_wr.data[1:0]), .q(pe_pur_q));

    spfs_cfg_reg #(.W(spfs_pkg::PB_W), .RST(spfs_pkg::PB_PER_RST)) u_pbpe (
        .core_clk(core_clk), .rstn(rstn), .we(pb_per_wr.we),
        .wdata(pb_per_wr.data[4:0]), .q(pb_per_q));
    spfs_cfg_reg #(.W(spfs_pkg::PF_W), .RST(spfs_pkg::PF_PER_RST)) u_pfpe (
        .core_clk(core_clk), .rstn(rstn), .we(pf_per_wr.we),
        .wdata(pf_per_wr.data[3:0]), .q(pf_per_q));
    spfs_cfg_reg #(.W(spfs_pkg::PD_W), .RST(spfs_pkg::PD_PER_RST)) u_pdpe (
        .core_clk(core_clk), .rstn(rstn), .we(pd_per_wr.we),
        .wdata(pd_per_wr.data), .q(pd_per_q));
    spfs_cfg_reg #(.W(spfs_pkg::PE_W), .RST(spfs_pkg::PE_PER_RST)) u_pepe (
        .core_clk(core_clk), .rstn(rstn), .we(pe_per_wr.we),
        .wdata(pe_per_wr.data[1:0]), .q(pe_per_q));

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clk_out_sel_q <= spfs_pkg::CLKO_RST;
        end else if (clk_out_sel_we) begin
            clk_out_sel_q <= clk_out_sel_wd;
        end
    end

    // -------------------------------------------------------------------
    // Per-pin selection tables (index: 0 B4, 1-4 F, 5-12 D, 13-14 E)
    // Pin order: [0]=B4 [1..4]=F0..3 [5..12]=D0..7 [13..14]=E0..1
    // -------------------------------------------------------------------
    wire logic bus_drive = bus_active | bus_drive_select;

    wire logic b4_per_out = (clk_out_sel_q == spfs_pkg::CLKO_PRESC)
                            ? prescaler_clk : address_line_twenty;
    wire logic b4_per_oe  = (clk_out_sel_q == spfs_pkg::CLKO_PRESC)
                            ? 1'b1 : bus_drive;

    logic [14:0] pin_per_en;
    logic [14:0] pin_per_out;
    logic [14:0] pin_per_oe;
    logic [14:0] pin_pu;

    assign pin_per_en  = {pe_per_q, pd_per_q, pf_per_q,
                          pb_per_q[spfs_pkg::PB_LINE4]};
    assign pin_pu      = {pe_pur_q, pd_pur_q, pf_pur_q,
                          pb_pur_q[spfs_pkg::PB_LINE4]};
    assign pin_per_out = {1'b1, serial_zero_transmit, 1'b1,
                          serial_one_transmit, cs_n_in, data_out,
                          b4_per_out};
    assign pin_per_oe  = {1'b0, 1'b1, 1'b0, 1'b1, {6{bus_drive}},
                          {4{bus_drive & data_oe}}, b4_per_oe};

    assign per_en_q = {3'h0, pin_per_en};

    // -------------------------------------------------------------------
    // Pad muxes
    // -------------------------------------------------------------------
    // pull-up bits map per line
    for (genvar i = 0; i < 15; i++) begin : g_pad
        spfs_pad_mux u_pad (
            .core_clk(core_clk),
            .rstn    (rstn),
            .per_en  (pin_per_en[i]),
            .gpio_dir(gpio_dir[i]),
            .gpio_out(gpio_out[i]),
            .per_out (pin_per_out[i]),
            .per_oe  (pin_per_oe[i]),
            .pu_en   (pin_pu[i]),
            .pad     (pads[i])
        );
    end
    // Unused upper pad slots held idle
    assign pads[17:15] = '{default: '{out: 1'b0, oe_n: 1'b1, pu: 1'b0}};

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_b4_reset_gpio: assert property (@(posedge core_clk)
        !rstn |=> !pin_per_en[0]) else $error("line four not gpio");
    a_clk_sel_route: assert property (@(posedge core_clk) disable iff (!rstn)
        pin_per_en[0] && clk_out_sel_q |=> pads[0].out == $past(prescaler_clk))
        else $error("clock route wrong");
    a_pu_b4_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        pb_pur_wr.we && !pb_pur_wr.data[4] |=> ##1 !pads[0].pu)
        else $error("b4 pull-up stuck");
    a_bus_idle_tri: assert property (@(posedge core_clk) disable iff (!rstn)
        pin_per_en[5] && !bus_active && !bus_drive_select |=> pads[5].oe_n)
        else $error("bus not tri-stated");
    a_pf_reset_bus: assert property (@(posedge core_clk)
        !rstn |=> pf_per_q == spfs_pkg::PF_PER_RST) else $error("port f rst");
    a_pf_pu_bit: assert property (@(posedge core_clk) disable iff (!rstn)
        pf_pur_wr.we && !pf_pur_wr.data[0] |=> ##1 !pads[1].pu)
        else $error("f0 pull-up stuck");
    a_pd_reset_gpio: assert property (@(posedge core_clk)
        !rstn |=> pd_per_q[5:0] == 6'h00) else $error("cs not gpio");
    a_pd_pu_bit: assert property (@(posedge core_clk) disable iff (!rstn)
        pd_pur_wr.we && !pd_pur_wr.data[6] |=> ##1 !pads[11].pu)
        else $error("d6 pull-up stuck");
    a_pu_reset_one: assert property (@(posedge core_clk)
        !rstn |=> (&pd_pur_q) && (&pe_pur_q)) else $error("pull-up rst");
    a_cs_route: assert property (@(posedge core_clk) disable iff (!rstn)
        pin_per_en[5] |=> pads[5].out == $past(cs_n_in[0]))
        else $error("chip select route wrong");
    a_pd_pu_d0: assert property (@(posedge core_clk) disable iff (!rstn)
        pd_pur_wr.we && !pd_pur_wr.data[0] |=> ##1 !pads[5].pu)
        else $error("d0 pull-up stuck");
    a_tx0_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        pin_per_en[13] |=> !pads[13].oe_n
            && pads[13].out == $past(serial_zero_transmit))
        else $error("tx0 not driven");
    a_rx0_undriven: assert property (@(posedge core_clk) disable iff (!rstn)
        pin_per_en[14] |=> pads[14].oe_n)
        else $error("rx0 driven");
    a_gpio_dir_ind: assert property (@(posedge core_clk) disable iff (!rstn)
        !pin_per_en[3] |=> pads[3].oe_n == !$past(gpio_dir[3]))
        else $error("direction wrong");
endmodule // spfs_top

// >>> shared/spfs_pkg.sv
package spfs_pkg;

    // -------------------------------------------------------------------
    // Widths and bit positions
    // -------------------------------------------------------------------
    localparam int PB_W       = 5;   // Port B lines held (0..4)
    localparam int PF_W       = 4;   // Port F lines
    localparam int PD_W       = 8;   // Port D lines (0..5 cs, 6 tx, 7 rx)
    localparam int PE_W       = 2;   // Port E lines
    localparam int PB_LINE4   = 4;   // Port B line four bit
    localparam int PD_CS_N    = 6;   // Chip select lines on port D
    localparam int PD_TX1     = 6;   // Serial one transmit bit
    localparam int PE_TX0     = 0;   // Serial zero transmit bit
    localparam int PE_RX0     = 1;   // Serial zero receive bit

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [PB_W-1:0] PB_PUR_RST = 5'h1F;
    localparam logic [PF_W-1:0] PF_PUR_RST = 4'hF;
    localparam logic [PD_W-1:0] PD_PUR_RST = 8'hFF;
    localparam logic [PE_W-1:0] PE_PUR_RST = 2'h3;
    localparam logic [PB_W-1:0] PB_PER_RST = 5'h00;
    localparam logic [PF_W-1:0] PF_PER_RST = 4'hF;
    localparam logic [PD_W-1:0] PD_PER_RST = 8'hC0;
    localparam logic [PE_W-1:0] PE_PER_RST = 2'h3;
    localparam logic            CLKO_RST   = 1'b0;

    // Clock out select encodings
    localparam logic CLKO_ADDR = 1'b0;
    localparam logic CLKO_PRESC = 1'b1;

    // Pad control for one pin
    typedef struct packed {
        logic out;   // Level driven
        logic oe_n;  // Low while driving
        logic pu;    // Pull-up on
    } spfs_pad_t;

    // Software writes for one port
    typedef struct packed {
        logic we;          // Write strobe
        logic [7:0] data;  // Value written
    } spfs_wr_t;

endpackage

// >>> sim/spfs_pin_model.sv
`timescale 1ns/1ps
// Board side of the shared pins: turns pad controls into wire levels
module spfs_pin_model (
    input  wire logic                       core_clk, // System clock
    input  wire spfs_pkg::spfs_pad_t [17:0] pads,     // Pad controls
    output logic                     [17:0] pin       // Wire levels
);
    // -------------------------------------------------------------------
    // Wire resolution
    // -------------------------------------------------------------------
    // released wire: pull-up level, else inverse of the pad's current out level
    always @(posedge core_clk) begin
        for (int i = 0; i < 18; i++) begin
            if (!pads[i].oe_n) pin[i] <= pads[i].out;
            else if (pads[i].pu) pin[i] <= 1'b1;
            else pin[i] <= ~pads[i].out;
        end
    end
endmodule // spfs_pin_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                       core_clk, rstn, cs_we, cs_wd, drv, act;
    logic                       a20, presc, d_oe, tx0, tx1, cs_q;
    logic                [17:0] dir, gout, per_en, pin;
    logic                 [3:0] d_out, pf_pur;
    logic                 [5:0] cs_n;
    logic                 [4:0] pb_pur;
    logic                 [7:0] pd_pur;
    logic                 [1:0] pe_pur;
    spfs_pkg::spfs_wr_t         wr [8];
    spfs_pkg::spfs_pad_t [17:0] pads;
    int                         failures, n_checks;

    // Design and board model
    spfs_top dut_u (.core_clk(core_clk), .rstn(rstn), .pb_pur_wr(wr[0]),
        .pf_pur_wr(wr[1]), .pd_pur_wr(wr[2]), .pe_pur_wr(wr[3]),
        .pb_per_wr(wr[4]), .pf_per_wr(wr[5]), .pd_per_wr(wr[6]),
        .pe_per_wr(wr[7]), .clk_out_sel_we(cs_we), .clk_out_sel_wd(cs_wd),
        .gpio_dir(dir), .gpio_out(gout), .bus_drive_select(drv),
        .bus_active(act), .address_line_twenty(a20), .prescaler_clk(presc),
        .data_out(d_out), .data_oe(d_oe), .cs_n_in(cs_n),
        .serial_zero_transmit(tx0), .serial_one_transmit(tx1), .pads(pads),
        .pb_pur_q(pb_pur), .pf_pur_q(pf_pur), .pd_pur_q(pd_pur),
        .pe_pur_q(pe_pur), .per_en_q(per_en), .clk_out_sel_q(cs_q));
    spfs_pin_model pin_u (.core_clk(core_clk), .pads(pads), .pin(pin));

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic chk(string name, logic [17:0] seen, logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(int idx, logic [7:0] d);
        @(negedge core_clk);
        wr[idx] = '{1'b1, d};
        @(negedge core_clk);
        wr[idx].we = 1'b0;
    endtask
    task automatic sel_clk(logic v);
        @(negedge core_clk);
        cs_we = 1'b1;
        cs_wd = v;
        @(negedge core_clk);
        cs_we = 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200us;
        failures++;
        end_sim();
    end

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        {rstn, cs_we, cs_wd, drv, act, a20, presc, d_oe, tx1} = '0;
        tx0 = 1'b1;
        {dir, gout, d_out, cs_n} = '0;
        for (int i = 0; i < 8; i++) wr[i] = '0;
        failures = 0;
        n_checks = 0;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        chk("pull_ups", {pb_pur, pf_pur, pd_pur, pe_pur}, 18'h3FFFF);
        chk("per_en", per_en, 18'h0781E);
        chk("clk_sel", cs_q, 18'h0);
        settle();
        chk("b4_pad", pads[0], 18'h3);
        chk("tx0_pad", pads[13], 18'h5);
        chk("tx1_pad", pads[11], 18'h1);
        chk("rx0_oe_n", pads[14].oe_n, 18'h1);
        chk("f0_idle", pads[1].oe_n, 18'h1);
        chk("b4_pin", pin[0], 18'h1);
        chk("spare_pads", pads[17:15], 18'h092);
        wr_reg(0, 8'hEF);
        wr_reg(1, 8'hFE);
        wr_reg(2, 8'hBF);
        wr_reg(3, 8'h02);
        settle();
        chk("pb_pur", pb_pur, 18'h0F);
        chk("pf_pur", {pf_pur, pads[1].pu, pads[2].pu}, 18'h39);
        chk("pd_pur", {pd_pur, pads[11].pu, pads[5].pu}, 18'h2FD);
        chk("pe_pur", {pe_pur, pads[13].pu, pads[14].pu}, 18'h9);
        chk("b4_pu", pads[0].pu, 18'h0);
        wr_reg(3, 8'h01);
        settle();
        chk("rx0_pu", {pe_pur, pads[14].pu}, 18'h2);
        wr_reg(4, 8'h10);
        sel_clk(1'b0);
        {a20, act} = 2'b11;
        settle();
        chk("a20_hi", {pads[0].out, pads[0].oe_n}, 18'h2);
        a20 = 1'b0;
        settle();
        chk("a20_lo", pads[0].out, 18'h0);
        act = 1'b0;
        settle();
        chk("a20_idle", pads[0].oe_n, 18'h1);
        drv = 1'b1;
        settle();
        chk("a20_drv", pads[0].oe_n, 18'h0);
        sel_clk(1'b1);
        {drv, presc} = 2'b01;
        settle();
        chk("presc_hi", {cs_q, pads[0].out, pads[0].oe_n}, 18'h6);
        presc = 1'b0;
        settle();
        chk("presc_lo", pads[0].out, 18'h0);
        wr_reg(6, 8'hFF);
        {cs_n, act, d_oe, d_out} = {6'h2A, 2'b11, 4'h5};
        settle();
        for (int i = 0; i < 6; i++)
            chk("cs_pad", {pads[5 + i].out, pads[5 + i].oe_n}, {cs_n[i], 1'b0});
        for (int i = 0; i < 4; i++)
            chk("data_pad", {pads[1 + i].out, pads[1 + i].oe_n}, {d_out[i], 1'b0});
        act = 1'b0;
        settle();
        for (int i = 0; i < 6; i++) chk("cs_idle", pads[5 + i].oe_n, 18'h1);
        // software moves every line of ports B, F, D and E to general I/O
        wr_reg(5, 8'h00);
        wr_reg(4, 8'h00);
        wr_reg(6, 8'h00);
        wr_reg(7, 8'h00);
        gout = 18'h0AAAA;
        for (int p = 0; p < 2; p++) begin
            dir = p ? 18'h05555 : 18'h02AAA;
            settle();
            for (int i = 0; i < 15; i++) begin
                chk("gpio_oe_n", pads[i].oe_n, {17'h0, ~dir[i]});
                if (dir[i]) chk("gpio_pin", pin[i], {17'h0, gout[i]});
            end
        end
        end_sim();
    end
endmodule // tb_top
